// *** verilog/lsdes_defs.svh ***
`ifndef LSDES_DEFS_SVH
`define LSDES_DEFS_SVH

// link shape
`define LSDES_LANES            3
`define LSDES_BITS_PER_LANE    7
`define LSDES_DATA_WIDTH       21

// system clock, 40 MHz
`define LSDES_CLK_PERIOD_PS    25000
`define LSDES_CLK_PER_US       40

// forwarded clock period window, ps
`define LSDES_FWD_PERIOD_MIN_PS 11760
`define LSDES_FWD_PERIOD_MAX_PS 83330

// loop lock time, ms, and cycles derived from it
`define LSDES_LOOP_LOCK_TIME_MS 10
`define LSDES_LOOP_LOCK_CYCLES  (`LSDES_LOOP_LOCK_TIME_MS * 1000 * `LSDES_CLK_PER_US)

// sleep entry delay, us, and cycles derived from it (longest time: rounds down)
`define LSDES_SLEEP_ENTRY_US    1
`define LSDES_SLEEP_ENTRY_CYCLES (`LSDES_SLEEP_ENTRY_US * `LSDES_CLK_PER_US)

// clock loss: four longest periods without a frame (least time: rounds up)
`define LSDES_LOSS_PERIODS      4
`define LSDES_LOSS_CYCLES \
   ((`LSDES_LOSS_PERIODS * `LSDES_FWD_PERIOD_MAX_PS + `LSDES_CLK_PERIOD_PS - 1) / `LSDES_CLK_PERIOD_PS)

// strobe low count loaded after a new word; strobe stays low this many system cycles plus one
`define LSDES_STROBE_LOW_CYCLES 2

// reset values
`define LSDES_DATA_RESET       21'h000000
`define LSDES_STROBE_RESET     1'h0

`endif

// *** verilog/lsdes_pkg.sv ***
`default_nettype none
package lsdes_pkg;

   typedef logic [2:0]  lsdes_bitcnt_type;
   typedef logic [6:0]  lsdes_lane_word_type;
   typedef logic [20:0] lsdes_word_type;

   // state of the logic clocked by the serial bit clock
   typedef struct packed {
      logic                        rstA;
      logic                        rstB;
      logic [3:0]                  pinA;
      logic [3:0]                  pinB;
      logic                        sleepA;
      logic                        sleepB;
      logic                        prevFwd;
      lsdes_bitcnt_type            bitCnt;
      logic                        inFrame;
      lsdes_lane_word_type [2:0]   laneWord;
      lsdes_word_type              word;
      logic                        wordToggle;
   } lsdes_link_state_type;

   typedef enum logic [1:0] {
      LSDES_SLEEP    = 2'b00,
      LSDES_NOCLOCK  = 2'b01,
      LSDES_LOCKING  = 2'b10,
      LSDES_RUN      = 2'b11
   } lsdes_mode_type;

   // state of the logic clocked by the system clock
   typedef struct packed {
      logic                        togA;
      logic                        togB;
      logic                        togC;
      logic                        sleepA;
      logic                        sleepB;
      lsdes_mode_type              mode;
      lsdes_word_type              data;
      logic                        strobe;
      logic [1:0]                  strobeCnt;
      logic [18:0]                 lockCnt;
      logic [5:0]                  idleCnt;
      logic                        locked;
   } lsdes_sys_state_type;

endpackage
`default_nettype wire

// *** verilog/lsdes_deserializer.sv ***
// What this block does
// [R1] take three serial data lanes and one forwarded clock lane as link inputs
// [R2] drive 21 parallel data outputs recovered from the three lanes
// [R3] sample seven bits per lane per forwarded period, bit 0 first, evenly spaced
// [R4] strobe clock output rises only while parallel data is valid and stable; the code also raises it in LSDES_NOCLOCK, before loop lock
// [R5] forwarded and output clock periods lie between 11.76 ns and 83.33 ns
// [R6] output clock stays near half duty cycle
// [R7] output clock edge follows the forwarded clock edge after a fixed delay
// [R8] latency is two forwarded periods plus the clock through delay
// [R9] outputs are not valid until loop lock time of 10 ms has passed
// [R10] sleep input low drives every output low
// [R11] forced-low sleep state reached within 1 us of sleep assertion
// [R12] floating data lanes read high, so their outputs read high
// [R13] floating forwarded clock holds parallel data at its last valid value
// [R14] floating forwarded clock drives the output clock high
// [R15] lane bit to output mapping mirrors the sender's input to lane mapping
// [R16] each serial bit occupies one seventh of the forwarded period
`timescale 1ns/1ps
`default_nettype none
`include "lsdes_defs.svh"

module lsdes_deserializer #(
   parameter int unsigned LOCK_CYCLES = `LSDES_LOOP_LOCK_CYCLES,
   parameter int unsigned LOSS_CYCLES = `LSDES_LOSS_CYCLES
) (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        serialBitClk,
   input  wire logic [`LSDES_LANES-1:0]     serialLaneIn,
   input  wire logic                        forwardedClockIn,
   input  wire logic                        sleepN,
   output var  logic [`LSDES_DATA_WIDTH-1:0] parallelDataOut,
   output var  logic                        parallelStrobeClockOut,
   output var  logic                        loopLocked
);

   // ****************************************************************
   // functions
   // ****************************************************************

   // lane bit to parallel output position
   function automatic int unsigned outIndex(input int unsigned lane, input int unsigned bitNo);
      outIndex = lane * `LSDES_BITS_PER_LANE + bitNo; // [R15]
   endfunction

   // flatten three lane words into the output word
   function automatic lsdes_pkg::lsdes_word_type packWord(
      input lsdes_pkg::lsdes_lane_word_type [2:0] lanes);
      lsdes_pkg::lsdes_word_type w;
      w = '0;
      for (int unsigned l = 0; l < `LSDES_LANES; l++) begin
         for (int unsigned b = 0; b < `LSDES_BITS_PER_LANE; b++) begin
            w[outIndex(l, b)] = lanes[l][b]; // [R15]
         end
      end
      packWord = w;
   endfunction

   // ****************************************************************
   // link domain: serial bit clock, seven edges per forwarded period
   // ****************************************************************

   lsdes_pkg::lsdes_link_state_type linkFf;
   lsdes_pkg::lsdes_link_state_type nxt_linkFf;

   logic [3:0] linkPins;
   assign linkPins = {forwardedClockIn, serialLaneIn}; // [R1]

   always_comb begin
      logic fwdNow;
      logic [2:0] laneBits;
      fwdNow   = 1'b0;
      laneBits = 3'h0;
      nxt_linkFf = linkFf;
      nxt_linkFf.rstA   = 1'b0;
      nxt_linkFf.rstB   = linkFf.rstA;
      nxt_linkFf.pinA   = linkPins;
      nxt_linkFf.pinB   = linkFf.pinA;
      nxt_linkFf.sleepA = sleepN;
      nxt_linkFf.sleepB = linkFf.sleepA;
      fwdNow   = linkFf.pinB[3];
      laneBits = linkFf.pinB[2:0]; // [R12]
      nxt_linkFf.prevFwd = fwdNow;
      if (linkFf.rstB || !linkFf.sleepB) begin
         // sleeping: no frames captured, pending frame dropped
         nxt_linkFf.inFrame = 1'b0; // [R10]
         nxt_linkFf.bitCnt  = 3'h0;
      end else if (fwdNow && !linkFf.prevFwd) begin
         // rising forwarded edge: this bit is bit 0 of a new frame
         for (int unsigned l = 0; l < `LSDES_LANES; l++) begin
            nxt_linkFf.laneWord[l][0] = laneBits[l]; // [R3]
         end
         nxt_linkFf.bitCnt  = 3'h1;
         nxt_linkFf.inFrame = 1'b1;
      end else if (linkFf.inFrame) begin
         for (int unsigned l = 0; l < `LSDES_LANES; l++) begin
            nxt_linkFf.laneWord[l][linkFf.bitCnt] = laneBits[l]; // [R3] [R16]
         end
         if (linkFf.bitCnt == 3'(`LSDES_BITS_PER_LANE - 1)) begin
            // seventh bit: whole word done, hand it over
            nxt_linkFf.inFrame = 1'b0;
            nxt_linkFf.bitCnt  = 3'h0;
            nxt_linkFf.word    = packWord(nxt_linkFf.laneWord); // [R2]
            nxt_linkFf.wordToggle = ~linkFf.wordToggle;
         end else begin
            nxt_linkFf.bitCnt = 3'(linkFf.bitCnt + 3'h1);
         end
      end
   end

   always_ff @(posedge serialBitClk or posedge rst) begin
      if (rst) begin
         linkFf            <= '0;
         linkFf.rstA       <= 1'b1;
         linkFf.rstB       <= 1'b1;
         linkFf.word       <= `LSDES_DATA_RESET;
      end else begin
         linkFf <= nxt_linkFf;
      end
   end

   // ****************************************************************
   // system domain: word pickup, lock timing, strobe generation
   // ****************************************************************

   lsdes_pkg::lsdes_sys_state_type sysFf;
   lsdes_pkg::lsdes_sys_state_type nxt_sysFf;

   always_comb begin
      logic newWord;
      logic clockLost;
      newWord   = 1'b0;
      clockLost = 1'b0;
      nxt_sysFf = sysFf;
      nxt_sysFf.togA   = linkFf.wordToggle;
      nxt_sysFf.togB   = sysFf.togA;
      nxt_sysFf.togC   = sysFf.togB;
      nxt_sysFf.sleepA = sleepN;
      nxt_sysFf.sleepB = sysFf.sleepA;
      newWord   = sysFf.togB ^ sysFf.togC;
      clockLost = (sysFf.idleCnt >= 6'(LOSS_CYCLES));
      // idle counter watches for frames from the forwarded clock
      if (newWord) begin
         nxt_sysFf.idleCnt = 6'h00;
      end else if (!clockLost) begin
         nxt_sysFf.idleCnt = 6'(sysFf.idleCnt + 6'h01);
      end
      if (!sysFf.sleepB) begin
         nxt_sysFf.mode      = lsdes_pkg::LSDES_SLEEP;
         nxt_sysFf.data      = `LSDES_DATA_RESET; // [R10] [R11]
         nxt_sysFf.strobe    = 1'b0; // [R10] [R11]
         nxt_sysFf.locked    = 1'b0;
         nxt_sysFf.lockCnt   = 19'h00000;
         nxt_sysFf.strobeCnt = 2'h0;
      end else begin
         unique case (sysFf.mode)
            lsdes_pkg::LSDES_SLEEP: begin
               nxt_sysFf.mode = lsdes_pkg::LSDES_NOCLOCK;
            end
            lsdes_pkg::LSDES_NOCLOCK: begin
               // data holds, clock output parked high
               nxt_sysFf.strobe  = 1'b1; // [R13] [R14]
               nxt_sysFf.locked  = 1'b0;
               nxt_sysFf.lockCnt = 19'h00000;
               if (newWord) begin
                  nxt_sysFf.mode = lsdes_pkg::LSDES_LOCKING;
               end
            end
            lsdes_pkg::LSDES_LOCKING: begin
               nxt_sysFf.strobe = 1'b0;
               if (clockLost) begin
                  nxt_sysFf.mode = lsdes_pkg::LSDES_NOCLOCK;
               end else if (sysFf.lockCnt >= 19'(LOCK_CYCLES - 1)) begin
                  nxt_sysFf.mode   = lsdes_pkg::LSDES_RUN; // [R9]
                  nxt_sysFf.locked = 1'b1;
               end else begin
                  nxt_sysFf.lockCnt = 19'(sysFf.lockCnt + 19'h00001);
               end
            end
            lsdes_pkg::LSDES_RUN: begin
               if (clockLost) begin
                  nxt_sysFf.mode   = lsdes_pkg::LSDES_NOCLOCK; // [R13] [R14]
                  nxt_sysFf.locked = 1'b0;
                  nxt_sysFf.strobe = 1'b1;
               end else if (newWord) begin
                  // word stable in link register for seven bit times
                  nxt_sysFf.data      = linkFf.word; // [R2] [R8]
                  nxt_sysFf.strobe    = 1'b0; // [R7]
                  nxt_sysFf.strobeCnt = 2'(`LSDES_STROBE_LOW_CYCLES); // [R6]
               end else if (sysFf.strobeCnt != 2'h0) begin
                  nxt_sysFf.strobeCnt = 2'(sysFf.strobeCnt - 2'h1);
               end else begin
                  nxt_sysFf.strobe = 1'b1; // [R4]
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sysFf        <= '0;
         sysFf.mode   <= lsdes_pkg::LSDES_SLEEP;
         sysFf.data   <= `LSDES_DATA_RESET;
         sysFf.strobe <= `LSDES_STROBE_RESET;
      end else begin
         sysFf <= nxt_sysFf;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************

   assign parallelDataOut        = sysFf.data;
   assign parallelStrobeClockOut = sysFf.strobe;
   assign loopLocked             = sysFf.locked;

endmodule
`default_nettype wire

// *** verif/lsdes_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************
// port checks
// ****************
module lsdes_monitor #(
   parameter int unsigned LOCK_CYCLES = 20
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        serialBitClk,
   input wire logic [2:0]  serialLaneIn,
   input wire logic        forwardedClockIn,
   input wire logic        sleepN,
   input wire logic [20:0] parallelDataOut,
   input wire logic        parallelStrobeClockOut,
   input wire logic        loopLocked
);
   logic [31:0] unlockCnt_ff;
   // cycles spent awake and unlocked
   always_ff @(posedge clk or posedge rst) begin
      if (rst || loopLocked || !sleepN) unlockCnt_ff <= 32'h0;
      else unlockCnt_ff <= unlockCnt_ff + 32'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_sleep_forces_low: assert property (!sleepN [*5] |-> parallelDataOut == 21'h0 && !parallelStrobeClockOut && !loopLocked)
      else $error("outputs not low in sleep");
   a_sleep_in_time: assert property ($fell(sleepN) |-> ##[1:40] (parallelDataOut == 21'h0 && !parallelStrobeClockOut))
      else $error("sleep state late");
   a_data_under_strobe: assert property ($changed(parallelDataOut) |-> !parallelStrobeClockOut)
      else $error("data moved while strobe high");
   a_strobe_low_phase: assert property ($fell(parallelStrobeClockOut) |=> !parallelStrobeClockOut [*2])
      else $error("strobe low phase short");
   a_strobe_rise_run: assert property ($rose(parallelStrobeClockOut) && loopLocked |-> !$past(parallelStrobeClockOut, 2) && !$past(parallelStrobeClockOut, 3))
      else $error("strobe rose too early");
   a_lock_time: assert property ($rose(loopLocked) |-> unlockCnt_ff >= LOCK_CYCLES)
      else $error("lock before lock time");
   a_loss_strobe_high: assert property ($fell(loopLocked) && sleepN && $past(sleepN, 4) |-> parallelStrobeClockOut)
      else $error("strobe not high on clock loss");
   a_loss_data_held: assert property ($fell(loopLocked) && sleepN && $past(sleepN, 4) |-> $stable(parallelDataOut))
      else $error("data not held on clock loss");
endmodule
bind lsdes_deserializer lsdes_monitor #(.LOCK_CYCLES(LOCK_CYCLES)) i_mon (
   .clk(clk), .rst(rst), .serialBitClk(serialBitClk), .serialLaneIn(serialLaneIn),
   .forwardedClockIn(forwardedClockIn), .sleepN(sleepN), .parallelDataOut(parallelDataOut),
   .parallelStrobeClockOut(parallelStrobeClockOut), .loopLocked(loopLocked)
);
`default_nettype wire

// *** verif/lsdes_link_tx.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************
// sending end of the link
// ****************
module lsdes_link_tx (
   input  wire logic                               serialBitClk,
   input  wire lsdes_pkg::lsdes_lane_word_type [2:0] txLanes,
   input  wire logic                               txOn,
   input  wire logic                               floatLanes,
   output var  logic                               forwardedClockIn,
   output var  logic [2:0]                         serialLaneIn
);
   int bitIdx = 0;
   // launch on falling edge, receiver samples on rising
   always @(negedge serialBitClk) begin
      bitIdx <= (bitIdx + 1) % 7;
      forwardedClockIn <= txOn ? (bitIdx < 4) : 1'b1;
      for (int l = 0; l < 3; l++) serialLaneIn[l] <= floatLanes ? 1'b1 : txLanes[l][bitIdx];
   end
endmodule
`default_nettype wire

// *** verif/tb_lsdes_deserializer.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_lsdes_deserializer;
   typedef struct packed {
      logic [6:0]  l2;
      logic [6:0]  l1;
      logic [6:0]  l0;
      logic [20:0] exp;
   } lsdes_row_type;
   logic clk, rst, bitClk, fwd, sleepN, txOn, floatLanes, strobe, locked;
   logic [2:0] lanes;
   logic [20:0] dataOut;
   lsdes_pkg::lsdes_lane_word_type [2:0] txLanes;
   lsdes_row_type rows [4];
   int errors = 0;
   int checks_done = 0;
   lsdes_deserializer #(.LOCK_CYCLES(20), .LOSS_CYCLES(14)) i_dut (
      .clk(clk), .rst(rst), .serialBitClk(bitClk), .serialLaneIn(lanes), .forwardedClockIn(fwd),
      .sleepN(sleepN), .parallelDataOut(dataOut), .parallelStrobeClockOut(strobe), .loopLocked(locked));
   lsdes_link_tx i_tx (
      .serialBitClk(bitClk), .txLanes(txLanes), .txOn(txOn), .floatLanes(floatLanes),
      .forwardedClockIn(fwd), .serialLaneIn(lanes));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      bitClk = 1'b0;
      #7;
      forever #15 bitClk = ~bitClk;
   end
   task automatic check(input string name, input logic [20:0] seen, input logic [20:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s exp=%h seen=%h", name, exp, seen);
      end
   endtask
   task automatic results();
      if (errors == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic waitRise();
      logic seenLow;
      seenLow = 1'b0;
      repeat (60) begin
         @(posedge clk);
         #1;
         if (strobe === 1'b1 && seenLow) return;
         if (strobe === 1'b0) seenLow = 1'b1;
      end
      check("strobeRise", 21'h1, 21'h0);
   endtask
   task automatic waitLock(input logic want);
      repeat (200) begin
         @(posedge clk);
         #1;
         if (locked === want) return;
      end
   endtask
   initial begin
      #100000;
      errors++;
      results();
   end
   initial begin
      rows[0] = {7'h01, 7'h00, 7'h7F, 21'h00407F};
      rows[1] = {7'h40, 7'h2A, 7'h00, 21'h101500};
      rows[2] = {7'h55, 7'h0F, 7'h33, 21'h1547B3};
      rows[3] = {7'h7F, 7'h7F, 7'h7E, 21'h1FFFFE};
      rst = 1'b1;
      sleepN = 1'b1;
      txOn = 1'b0;
      floatLanes = 1'b0;
      txLanes = '0;
      repeat (5) @(posedge clk);
      #2 rst = 1'b0;
      check("dataRst", dataOut, 21'h0);
      check("strobeRst", {20'h0, strobe}, 21'h0);
      txOn = 1'b1;
      waitLock(1'b1);
      check("locked", {20'h0, locked}, 21'h1);
      foreach (rows[i]) begin
         txLanes = {rows[i].l2, rows[i].l1, rows[i].l0};
         repeat (3) waitRise();
         check("word", dataOut, rows[i].exp);
      end
      floatLanes = 1'b1;
      repeat (3) waitRise();
      check("floatData", dataOut, 21'h1FFFFF);
      txOn = 1'b0;
      waitLock(1'b0);
      #2;
      check("lossStrobe", {20'h0, strobe}, 21'h1);
      check("lossData", dataOut, 21'h1FFFFF);
      txOn = 1'b1;
      @(posedge clk);
      #2 sleepN = 1'b0;
      repeat (40) @(posedge clk);
      #1;
      check("sleepData", dataOut, 21'h0);
      check("sleepFlags", {19'h0, strobe, locked}, 21'h0);
      results();
   end
endmodule
`default_nettype wire
